//--- seq_ctrl.sv
`include "seq_ctrl_cfg.svh"
`timescale 1ns/10ps
`default_nettype none

module seq_ctrl
    import seq_ctrl_pkg::*;
(
    input wire logic clk_sys, // System clock, 20 MHz
    input wire logic rst, // Synchronous reset, active high
    input wire reg_req_t reg_req, // Register access request
    output logic [15:0] reg_rdata_q, // Read data
    output logic reg_rvalid_q, // Read data valid pulse
    output logic pump_on, // Charge pump enable
    output logic conv_powered_q, // Converter power on
    output logic conv_busy, // Sequence in progress
    output logic conv_start, // Start one conversion pulse
    output conv_req_t conv_req_q, // Item being converted
    input wire logic conv_done // Converter finished item
);

    localparam logic [11:0] WAKE_CNT = 12'(`WAKE_CYCLES);

    logic [15:0] pump_q; // Charge pump register
    logic [15:0] conv_q; // Conversion control register
    logic [15:0] diag_q; // Diagnostic selector register
    seq_state_t state_q; // Sequencer state
    logic [11:0] wake_q; // Power-up counter
    logic [2:0] item_q; // Current item index
    logic [`NUM_ITEMS-1:0] mask; // Enabled items
    logic [1:0] mode; // Sequencing mode field
    logic conv_wr; // Write to conversion control
    logic [3:0] next_res; // Found flag and index of next item
    logic [3:0] first_res; // First enabled item
    logic advance; // Current item over, next one chosen
    logic [2:0] pick; // Item that the next start converts

    // Effective diagnostic rate, unlisted codes act as 20 SPS
    function automatic logic [1:0] eff_rate(input logic [1:0] code);
        if (code == `RATE_4K8 || code == `RATE_9K6)
        begin
            eff_rate = code;
        end
        else
        begin
            eff_rate = `RATE_20SPS;
        end
    endfunction

    // Node measured by a slot for a given selector code
    function automatic logic [4:0] node_of(input logic [1:0] slot,
                                           input logic [3:0] code);
        logic [4:0] n;
        n = {1'b0, code};
        if (code == `SEL_GND_B)
        begin
            n = {1'b0, `SEL_GND_A};
        end
        else if (code == `SEL_CURRENT)
        begin
            unique case (slot)
                2'h3: n = `NODE_INT_SRC;
                2'h2: n = `NODE_INT_SNK;
                2'h1: n = `NODE_EXT_SRC;
                2'h0: n = `NODE_EXT_SNK;
            endcase
        end
        node_of = n;
    endfunction

    // First enabled item at or after a start index
    function automatic logic [3:0] find_item(
        input logic [`NUM_ITEMS-1:0] m, input logic [2:0] from);
        logic [3:0] r;
        r = 4'h0;
        for (int i = `NUM_ITEMS - 1; i >= 0; i--)
        begin
            if (m[i] && 3'(i) >= from)
            begin
                r = {1'b1, 3'(i)};
            end
        end
        find_item = r;
    endfunction

    // Item order: meas1, meas2, slot0..slot3
    assign mask = {conv_q[`POS_SLOT_HI:`POS_SLOT_LO],
                   conv_q[`POS_MEAS2], conv_q[`POS_MEAS1]};
    assign mode = conv_q[`POS_MODE_HI:`POS_MODE_LO];
    assign conv_wr = reg_req.wr && reg_req.addr == `OFS_CONV;
    assign next_res = find_item(mask, 3'(item_q + 3'h1));
    assign first_res = find_item(mask, 3'h0);
    // Same choice the state machine makes when it leaves the wait state
    assign advance = state_q == ST_WAIT && (item_q == 3'h7 || conv_done);
    assign pick = (item_q != 3'h7 && next_res[3]) ? next_res[2:0]
                                                  : first_res[2:0];
    assign pump_on = pump_q[`POS_PUMP_ON];
    assign conv_busy = state_q == ST_WAKE || state_q == ST_ISSUE
                       || state_q == ST_WAIT;
    assign conv_start = state_q == ST_ISSUE;

    // Charge pump register
    always_ff @(posedge clk_sys)
    begin
        if (rst)
        begin
            pump_q <= `RST_PUMP;
        end
        else if (reg_req.wr && reg_req.addr == `OFS_PUMP)
        begin
            pump_q <= reg_req.wdata & `MASK_PUMP;
        end
    end

    // Conversion control register
    always_ff @(posedge clk_sys)
    begin
        if (rst)
        begin
            conv_q <= `RST_CONV;
        end
        else if (conv_wr)
        begin
            conv_q <= reg_req.wdata & `MASK_CONV;
        end
    end

    // Diagnostic selector register
    always_ff @(posedge clk_sys)
    begin
        if (rst)
        begin
            diag_q <= `RST_DIAG;
        end
        else if (reg_req.wr && reg_req.addr == `OFS_DIAG)
        begin
            diag_q <= reg_req.wdata & `MASK_DIAG;
        end
    end

    // Register read port, one cycle latency
    always_ff @(posedge clk_sys)
    begin
        if (rst)
        begin
            reg_rdata_q <= 16'h0000;
            reg_rvalid_q <= 1'b0;
        end
        else
        begin
            reg_rvalid_q <= reg_req.rd;
            if (reg_req.rd)
            begin
                unique case (reg_req.addr)
                    `OFS_PUMP: reg_rdata_q <= pump_q;
                    `OFS_CONV: reg_rdata_q <= conv_q;
                    `OFS_DIAG: reg_rdata_q <= diag_q;
                    default: reg_rdata_q <= 16'h0000; // Unmapped
                endcase
            end
        end
    end

    // Sequencer state machine
    always_ff @(posedge clk_sys)
    begin
        if (rst)
        begin
            state_q <= ST_IDLE;
            conv_powered_q <= 1'b1;
            wake_q <= 12'h000;
            item_q <= 3'h0;
        end
        else
        begin
            unique case (state_q)
                // Idle or powered down, waiting for a start write
                ST_IDLE, ST_OFF:
                begin
                    if (conv_wr && reg_req.wdata[`POS_MODE_HI:`POS_MODE_LO]
                        == `MODE_PDOWN)
                    begin
                        state_q <= ST_OFF;
                        conv_powered_q <= 1'b0;
                    end
                    else if (conv_wr && (reg_req.wdata[`POS_MODE_HI:
                             `POS_MODE_LO] == `MODE_SINGLE
                             || reg_req.wdata[`POS_MODE_HI:`POS_MODE_LO]
                             == `MODE_CONT))
                    begin
                        item_q <= 3'h7; // Search restarts from item 0
                        conv_powered_q <= 1'b1;
                        wake_q <= 12'h000;
                        if (state_q == ST_OFF)
                        begin
                            state_q <= ST_WAKE;
                        end
                        else
                        begin
                            state_q <= ST_WAIT;
                        end
                    end
                    else if (conv_wr)
                    begin
                        state_q <= ST_IDLE;
                        conv_powered_q <= 1'b1;
                    end
                end
                // Power-up interval after leaving power-down
                ST_WAKE:
                begin
                    wake_q <= wake_q + 12'h001;
                    if (wake_q == WAKE_CNT - 12'h001)
                    begin
                        state_q <= ST_WAIT;
                    end
                end
                // Start pulse for the current item
                ST_ISSUE:
                begin
                    state_q <= ST_WAIT;
                end
                // Wait for item end, then pick the next one
                ST_WAIT:
                begin
                    if (item_q == 3'h7 || conv_done)
                    begin
                        if (item_q != 3'h7 && next_res[3])
                        begin
                            item_q <= next_res[2:0];
                            state_q <= ST_ISSUE;
                        end
                        else if (mode == `MODE_CONT && first_res[3])
                        begin
                            item_q <= first_res[2:0];
                            state_q <= ST_ISSUE;
                        end
                        else if (item_q == 3'h7 && first_res[3]
                                 && mode == `MODE_SINGLE)
                        begin
                            item_q <= first_res[2:0];
                            state_q <= ST_ISSUE;
                        end
                        else if (mode == `MODE_PDOWN)
                        begin
                            state_q <= ST_OFF;
                            conv_powered_q <= 1'b0;
                        end
                        else
                        begin
                            state_q <= ST_IDLE;
                        end
                    end
                end
                default:
                begin
                    state_q <= ST_IDLE;
                end
            endcase
        end
    end

    // Request details for the item being converted
    always_ff @(posedge clk_sys)
    begin
        if (rst)
        begin
            conv_req_q <= '0;
        end
        else if (advance)
        begin
            // Loaded with the chosen item so it stands with the start pulse
            conv_req_q.item <= pick;
            conv_req_q.is_diag <= pick >= `FIRST_SLOT_ITEM;
            conv_req_q.rate <= eff_rate(conv_q[`POS_RATE_HI:`POS_RATE_LO]);
            unique case (pick)
                3'h2: conv_req_q.node <= node_of(2'h0, diag_q[3:0]);
                3'h3: conv_req_q.node <= node_of(2'h1, diag_q[7:4]);
                3'h4: conv_req_q.node <= node_of(2'h2, diag_q[11:8]);
                3'h5: conv_req_q.node <= node_of(2'h3, diag_q[15:12]);
                default: conv_req_q.node <= 5'h00; // Measurement items
            endcase
        end
    end

endmodule

`default_nettype wire

//--- seq_ctrl_cfg.svh
`ifndef SEQ_CTRL_CFG_SVH
`define SEQ_CTRL_CFG_SVH

// Register offsets on the register access port
`define OFS_PUMP 8'h3A
`define OFS_CONV 8'h3B
`define OFS_DIAG 8'h3C

// Reset values
`define RST_PUMP 16'h0000
`define RST_CONV 16'h0000
`define RST_DIAG 16'h0000

// Writable bit masks, reserved positions stay zero
`define MASK_PUMP 16'h0001
`define MASK_CONV 16'hFF03
`define MASK_DIAG 16'hFFFF

// Field positions in the charge pump register
`define POS_PUMP_ON 0

// Field positions in the conversion control register
`define POS_RATE_HI 15
`define POS_RATE_LO 14
`define POS_MODE_HI 13
`define POS_MODE_LO 12
`define POS_SLOT_HI 11
`define POS_SLOT_LO 8
`define POS_MEAS2 1
`define POS_MEAS1 0

// Sequencing mode codes
`define MODE_STANDBY 2'h0
`define MODE_SINGLE 2'h1
`define MODE_CONT 2'h2
`define MODE_PDOWN 2'h3

// Diagnostic rate codes, any other code behaves as the 20 SPS code
`define RATE_20SPS 2'h0
`define RATE_4K8 2'h1
`define RATE_9K6 2'h2

// Selector codes with a special meaning
`define SEL_GND_A 4'h0
`define SEL_GND_B 4'hE
`define SEL_CURRENT 4'hF

// Measured node codes: 0..13 follow the selector code directly
`define NODE_INT_SRC 5'h0E
`define NODE_INT_SNK 5'h0F
`define NODE_EXT_SRC 5'h10
`define NODE_EXT_SNK 5'h11

// Sequence items: two measurements then four diagnostic slots
`define NUM_ITEMS 6
`define FIRST_SLOT_ITEM 3'h2

// Converter power-up interval
`define WAKE_TIME_NS 100000
`define CLK_PERIOD_NS 50
`define WAKE_CYCLES ((`WAKE_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

`endif

//--- seq_ctrl_pkg.sv
package seq_ctrl_pkg;

    // Sequencer states
    typedef enum logic [2:0] {
        ST_IDLE,
        ST_OFF,
        ST_WAKE,
        ST_ISSUE,
        ST_WAIT
    } seq_state_t;

    // Conversion request handed to the analog converter
    typedef struct packed {
        logic [2:0] item;     // 0,1 measurements, 2..5 slots 0..3
        logic is_diag;        // Item is a diagnostic slot
        logic [4:0] node;     // Measured node for a diagnostic
        logic [1:0] rate;     // Effective diagnostic rate code
    } conv_req_t;

    // Register access port from the serial front end
    typedef struct packed {
        logic wr;             // Write strobe
        logic rd;             // Read strobe
        logic [7:0] addr;     // Register address
        logic [15:0] wdata;   // Write data
    } reg_req_t;

endpackage

//--- seq_ctrl_chk.sv
`timescale 1ns/10ps
`default_nettype none

// Port checker for the sequencer control block
module seq_ctrl_chk
    import seq_ctrl_pkg::*;
(
    input wire logic clk_sys, // Clock
    input wire logic rst, // Reset
    input wire reg_req_t reg_req, // Register request
    input wire logic [15:0] reg_rdata_q, // Read data
    input wire logic reg_rvalid_q, // Read valid
    input wire logic pump_on, // Pump enable
    input wire logic conv_powered_q, // Converter power
    input wire logic conv_busy, // Sequence busy
    input wire logic conv_start, // Start pulse
    input wire conv_req_t conv_req_q, // Current item
    input wire logic conv_done // Item finished
);
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (rst);

    // Write decodes
    wire logic pump_wr = reg_req.wr && reg_req.addr == 8'h3A; // Pump write
    wire logic conv_wr = reg_req.wr && reg_req.addr == 8'h3B; // Ctrl write

    chk_pump_write: assert property (
        pump_wr |=> pump_on == $past(reg_req.wdata[0]))
        else $error("pump enable differs from written bit");
    chk_pump_hold: assert property (
        !pump_wr |=> $stable(pump_on))
        else $error("pump enable moved without a write");
    chk_pump_rsvd: assert property (
        reg_rvalid_q && $past(reg_req.addr) == 8'h3A
        |-> reg_rdata_q[15:1] == 15'h0000)
        else $error("pump register reserved bits set");
    chk_conv_rsvd: assert property (
        reg_rvalid_q && $past(reg_req.addr) == 8'h3B
        |-> reg_rdata_q[7:2] == 6'h00)
        else $error("control register reserved bits set");
    chk_start_pulse: assert property (
        conv_start |=> !conv_start)
        else $error("start pulse longer than one cycle");
    chk_start_powered: assert property (
        conv_start |-> conv_busy && conv_powered_q)
        else $error("start while unpowered or not busy");
    chk_item_kind: assert property (
        conv_start |-> conv_req_q.is_diag == (conv_req_q.item >= 3'h2))
        else $error("item kind does not match item number");
    chk_rate_legal: assert property (
        conv_start && conv_req_q.is_diag |-> conv_req_q.rate != 2'h3)
        else $error("unlisted rate code passed through");
    chk_start_delay: assert property (
        conv_wr && reg_req.wdata[13:12] == 2'h1 && reg_req.wdata[0]
        && !conv_busy && conv_powered_q
        |-> ##[2:3] conv_start && conv_req_q.item == 3'h0)
        else $error("single sequence did not start with first item");
    chk_power_down: assert property (
        conv_wr && reg_req.wdata[13:12] == 2'h3 && !conv_busy
        |-> ##[1:2] !conv_powered_q)
        else $error("power down code left converter powered");

    // Main scenarios reached
    cov_last_slot: cover property (conv_start && conv_req_q.item == 3'h5);
    cov_pdown: cover property ($fell(conv_powered_q));
    cov_read: cover property (reg_rvalid_q);
endmodule

`default_nettype wire

//--- conv_model.sv
`timescale 1ns/10ps
`default_nettype none

// Converter stand-in, answers fast and slow in turn
module conv_model
(
    input wire logic clk_sys, // Clock
    input wire logic rst, // Reset
    input wire logic conv_start, // Start pulse
    output logic conv_done // Done pulse
);
    logic [2:0] cnt_q; // Cycles left
    logic slow_q; // Next answer is slow

    // One done pulse for every start
    always_ff @(posedge clk_sys)
    begin
        if (rst)
        begin
            cnt_q <= 3'h0;
            slow_q <= 1'b0;
            conv_done <= 1'b0;
        end
        else
        begin
            conv_done <= (cnt_q == 3'h1);
            if (conv_start)
            begin
                cnt_q <= slow_q ? 3'h5 : 3'h1;
                slow_q <= !slow_q;
            end
            else if (cnt_q != 3'h0)
                cnt_q <= cnt_q - 3'h1;
        end
    end
endmodule

`default_nettype wire

//--- seq_ctrl_tb.sv
`timescale 1ns/10ps
`default_nettype none
`define CHK(g, e) begin check_count++; if ((g) !== (e)) begin err_total++; \
    $display("wrong value at %0t got %0h exp %0h", $time, (g), (e)); end end

module seq_ctrl_tb
    import seq_ctrl_pkg::*;
;
    logic clk_sys = 1'b0; // Clock
    logic rst = 1'b1; // Reset
    reg_req_t reg_req = '0; // Register request
    logic [15:0] reg_rdata_q; // Read data
    logic reg_rvalid_q; // Read valid
    logic pump_on; // Pump enable
    logic conv_powered_q; // Converter power
    logic conv_busy; // Busy
    logic conv_start; // Start pulse
    conv_req_t conv_req_q; // Current item
    logic conv_done; // From converter model
    int err_total = 0; // Mismatches
    int check_count = 0; // Comparisons
    int start_count = 0; // Starts seen
    logic [15:0] exp_q[$]; // Expected results in order

    always #25 clk_sys = ~clk_sys;

    seq_ctrl uut (.clk_sys(clk_sys), .rst(rst), .reg_req(reg_req),
        .reg_rdata_q(reg_rdata_q), .reg_rvalid_q(reg_rvalid_q),
        .pump_on(pump_on), .conv_powered_q(conv_powered_q),
        .conv_busy(conv_busy), .conv_start(conv_start),
        .conv_req_q(conv_req_q), .conv_done(conv_done));
    conv_model conv (.clk_sys(clk_sys), .rst(rst), .conv_start(conv_start),
        .conv_done(conv_done));

    // Verdict and end of run
    task automatic wrap_up();
        $display("checks %0d errors %0d", check_count, err_total);
        if (err_total == 0 && check_count > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    // One-cycle register access, write or read
    task automatic acc(input logic w, input logic [7:0] a,
        input logic [15:0] d);
        @(posedge clk_sys);
        reg_req <= {w, !w, a, d};
        @(posedge clk_sys);
        reg_req.wr <= 1'b0;
        reg_req.rd <= 1'b0;
    endtask

    // Read with expected value noted
    task automatic rd(input logic [7:0] a, input logic [15:0] e);
        exp_q.push_back(e);
        acc(1'b0, a, 16'h0000);
    endtask

    // Wait until the sequence is over
    task automatic settle();
        repeat (3) @(posedge clk_sys);
        for (int i = 0; i < 3000 && conv_busy !== 1'b0; i++)
            @(posedge clk_sys);
        `CHK(conv_busy, 1'b0)
    endtask

    // Compare against oldest note
    task automatic chk_next(input logic [15:0] g);
        logic [15:0] e;
        if (exp_q.size() == 0)
        begin
            err_total++;
            $display("wrong value at %0t got %0h exp none", $time, g);
        end
        else
        begin
            e = exp_q.pop_front();
            `CHK(g, e)
        end
    endtask

    // Expected diagnostic item from slot, selector and rate
    function automatic logic [15:0] ei(input logic [2:0] s,
        input logic [3:0] c, input logic [1:0] r);
        logic [4:0] n;
        n = (c == 4'hF) ? 5'h11 - 5'(s) : (c == 4'hE) ? 5'h00 : {1'b0, c};
        return {5'h00, 3'h2 + s, 1'b1, n, (r == 2'h3) ? 2'h0 : r};
    endfunction

    // Output watcher
    always @(posedge clk_sys)
    begin
        if (!rst && reg_rvalid_q === 1'b1)
            chk_next(reg_rdata_q);
        if (!rst && conv_start === 1'b1)
        begin
            start_count++;
            if (exp_q.size() > 0 && exp_q[0][15])
                chk_next({5'h10, conv_req_q.item, conv_req_q.is_diag,
                    7'h00});
            else
                chk_next({5'h00, conv_req_q});
        end
    end

    // Main sequence
    initial
    begin
        logic [15:0] v;
        logic [15:0] sel[4];
        logic [3:0] se;
        logic [1:0] me;
        int n;
        void'($urandom(65));
        repeat (10) @(posedge clk_sys);
        rst <= 1'b0;
        rd(8'h3A, 16'h0000);
        rd(8'h3B, 16'h0000);
        rd(8'h3C, 16'h0000);
        rd(8'h3D, 16'h0000);
        `CHK(conv_powered_q, 1'b1)
        acc(1'b1, 8'h3A, 16'hFFFF);
        #1 `CHK(pump_on, 1'b1)
        rd(8'h3A, 16'h0001);
        acc(1'b1, 8'h3A, 16'h0000);
        #1 `CHK(pump_on, 1'b0)
        v = 16'($urandom);
        v[13:12] = 2'h0;
        acc(1'b1, 8'h3B, v);
        rd(8'h3B, v & 16'hFF03);
        acc(1'b1, 8'h3B, 16'h0000);
        sel = '{16'hFFFE, 16'h10EF, 16'($urandom), 16'($urandom)};
        for (int k = 0; k < 4; k++)
        begin
            se = (k == 1) ? 4'h5 : 4'hF;
            me = (k == 1) ? 2'h2 : 2'h3;
            acc(1'b1, 8'h3C, sel[k]);
            rd(8'h3C, sel[k]);
            for (int i = 0; i < 2; i++)
                if (me[i]) exp_q.push_back(16'h8000 | (16'(i) << 8));
            for (int s = 0; s < 4; s++)
                if (se[s]) exp_q.push_back(ei(3'(s), sel[k][4*s +: 4], 2'(k)));
            acc(1'b1, 8'h3B, {2'(k), 2'h1, se, 6'h00, me});
            settle();
        end
        // Continuous run stopped in the second sequence
        exp_q = {exp_q, 16'h8000, 16'h8100, 16'h8000, 16'h8100};
        n = start_count;
        acc(1'b1, 8'h3B, 16'h2003);
        for (int i = 0; i < 500 && start_count < n + 3; i++)
            @(posedge clk_sys);
        acc(1'b1, 8'h3B, 16'h0003);
        settle();
        `CHK(exp_q.size(), 0)
        `CHK(conv_powered_q, 1'b1)
        // Power down then a single sequence with wake time
        acc(1'b1, 8'h3B, 16'h3000);
        repeat (2) @(posedge clk_sys);
        `CHK(conv_powered_q, 1'b0)
        exp_q.push_back(ei(3'h0, sel[3][3:0], 2'h0));
        acc(1'b1, 8'h3B, 16'h1100);
        n = 0;
        while (conv_start !== 1'b1 && n < 3000)
        begin
            @(posedge clk_sys);
            n++;
        end
        `CHK(n >= 2000 && n <= 2005, 1'b1)
        settle();
        wrap_up();
    end

    // Watchdog against a hang
    initial
    begin
        #2000000;
        err_total++;
        wrap_up();
    end
endmodule

bind seq_ctrl seq_ctrl_chk chk (.clk_sys(clk_sys), .rst(rst),
    .reg_req(reg_req), .reg_rdata_q(reg_rdata_q),
    .reg_rvalid_q(reg_rvalid_q), .pump_on(pump_on),
    .conv_powered_q(conv_powered_q), .conv_busy(conv_busy),
    .conv_start(conv_start), .conv_req_q(conv_req_q),
    .conv_done(conv_done));

`default_nettype wire
